// ---- hdl/baseline_core.sv ----
// decode and execute core with avalon control slave
// Summary of operation
// - or, and, xor with file; zero only
// - rotates through carry; carry only
// - inc/dec skip if zero, no flags
// - bit ops: opcode, bit index, address
// - literal move/or/and/xor; logicals set zero
// - fixed control words decoded exactly
// - destination bit selects working or file
// - file move updates zero flag
// - file clear writes zero, sets zero
// - working clear zeroes, sets zero flag
// - store working into file, no flags
// - option load from working, no flags
// - call pushes next address, two cycles
// - call loads low byte, page, bit8 zero
// - return loads literal, pops counter
// - met skip turns next into nop
// - watchdog clear sets timeout, powerdown flags
// - sleep clears watchdog, halts, clears powerdown
// - port read-modify uses sampled pins
// - direction load port 6 from working
// - timer write clears prescaler only when it is assigned to timer
`default_nettype none
`include "core_params.svh"
module baseline_core
	import core_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire core_pkg::avs_req_t avs_req,
	output var core_pkg::avs_rsp_t avs_rsp,
	output logic [`PC_W-1:0] prog_addr,
	input wire logic [`INSN_W-1:0] prog_data,
	input wire logic [`PIN_W-1:0] pin_in,
	output logic [`PIN_W-1:0] pin_out,
	output logic [`PIN_W-1:0] pin_oe,
	output logic [7:0] option_out,
	output logic wdt_clear,
	output logic prescaler_clear,
	output logic sleeping
);
	import core_pkg::*;

	core_st_t s_q;
	core_st_t s_d;

	always_comb begin
		logic [`INSN_W-1:0] op;
		logic [4:0] fa;
		logic [7:0] fv;
		logic [7:0] res;
		logic [7:0] mask;
		logic [8:0] wide;
		logic [4:0] nib;
		logic wr_en;
		logic w_en;
		logic byte_op;
		logic z_en;
		logic c_en;
		logic c_val;
		logic dc_en;
		logic dc_val;
		logic skip;
		logic [1:0] av_sel;
		op = '0;
		fa = '0;
		fv = '0;
		res = '0;
		mask = '0;
		wide = '0;
		nib = '0;
		wr_en = 1'b0;
		w_en = 1'b0;
		byte_op = 1'b0;
		z_en = 1'b0;
		c_en = 1'b0;
		c_val = 1'b0;
		dc_en = 1'b0;
		dc_val = 1'b0;
		skip = 1'b0;
		av_sel = avs_req.address[3:2];
		s_d = s_q;
		s_d.wdt_clr = 1'b0;
		s_d.psc_clr = 1'b0;
		// pin synchroniser
		s_d.sync1 = pin_in;
		s_d.sync2 = s_q.sync1;

		// avalon slave
		if ((avs_req.read || avs_req.write) && s_q.av_wait) begin
			s_d.av_wait = 1'b0;
			case (av_sel)
				`AV_CTRL: s_d.av_rdata = {31'h0, s_q.run};
				`AV_CORE: s_d.av_rdata = {15'h0, s_q.sleeping, s_q.status, s_q.wreg};
				`AV_PC: s_d.av_rdata = {21'h0, s_q.pc};
				`AV_CONF: s_d.av_rdata = {20'h0, s_q.dir, s_q.option};
				default: s_d.av_rdata = 32'h0;
			endcase
		end else if (!s_q.av_wait) begin
			s_d.av_wait = 1'b1;
			if (avs_req.write && av_sel == `AV_CTRL) begin
				s_d.run = avs_req.writedata[`CTRL_RUN];
			end
		end

		if (s_q.sleeping) begin
			// wake on pin change when enabled
			if (!s_q.option[`OPT_WAKE_N] && s_q.sync2 != s_q.last_pins) begin
				s_d.sleeping = 1'b0;
				s_d.status[`ST_WAKE] = 1'b1;
			end
		end else if (s_q.run) begin
			s_d.ir = prog_data;
			s_d.pc = s_q.pc + `PC_W'(1);
			s_d.flush = 1'b0;
			op = s_q.flush ? `INSN_W'(0) : s_q.ir;
			fa = op[4:0];
			mask = 8'h01 << op[7:5];
			if (fa == `FILE_PORT) begin
				fv = {4'h0, s_q.sync2};
			end else if (fa == `FILE_STATUS) begin
				fv = s_q.status;
			end else begin
				fv = s_q.files[fa];
			end
			casez (op)
				12'b0000_0000_0000: begin
				end
				12'b0000_0000_0010: begin
					s_d.option = s_q.wreg;
				end
				12'b0000_0000_0011: begin
					s_d.wdt_clr = 1'b1;
					s_d.psc_clr = 1'b1;
					s_d.status[`ST_TO] = 1'b1;
					s_d.status[`ST_PD] = 1'b0;
					s_d.sleeping = 1'b1;
				end
				12'b0000_0000_0100: begin
					s_d.wdt_clr = 1'b1;
					s_d.psc_clr = s_q.option[`OPT_PSA];
					s_d.status[`ST_TO] = 1'b1;
					s_d.status[`ST_PD] = 1'b1;
				end
				12'b0000_0000_0???: begin
					if (op[2:0] == `DIR_PORT_SEL) begin
						s_d.dir = s_q.wreg[`PIN_W-1:0];
					end
				end
				12'b0000_001?_????: begin
					res = s_q.wreg;
					wr_en = 1'b1;
				end
				12'b0000_0100_0000: begin
					res = 8'h00;
					w_en = 1'b1;
					z_en = 1'b1;
				end
				12'b0000_011?_????: begin
					res = 8'h00;
					wr_en = 1'b1;
					z_en = 1'b1;
				end
				12'b0000_10??_????: begin
					wide = {1'b0, fv} - {1'b0, s_q.wreg};
					nib = {1'b0, fv[3:0]} - {1'b0, s_q.wreg[3:0]};
					res = wide[7:0];
					c_en = 1'b1;
					c_val = ~wide[8];
					dc_en = 1'b1;
					dc_val = ~nib[4];
					z_en = 1'b1;
					byte_op = 1'b1;
				end
				12'b0000_11??_????: begin
					res = fv - 8'h01;
					z_en = 1'b1;
					byte_op = 1'b1;
				end
				12'b0001_????_????: begin
					case (op[7:6])
						2'b00: res = s_q.wreg | fv;
						2'b01: res = s_q.wreg & fv;
						2'b10: res = s_q.wreg ^ fv;
						default: begin
							wide = {1'b0, fv} + {1'b0, s_q.wreg};
							nib = {1'b0, fv[3:0]} + {1'b0, s_q.wreg[3:0]};
							res = wide[7:0];
							c_en = 1'b1;
							c_val = wide[8];
							dc_en = 1'b1;
							dc_val = nib[4];
						end
					endcase
					z_en = 1'b1;
					byte_op = 1'b1;
				end
				12'b0010_????_????: begin
					byte_op = 1'b1;
					case (op[7:6])
						2'b00: begin
							res = fv;
							z_en = 1'b1;
						end
						2'b01: begin
							res = ~fv;
							z_en = 1'b1;
						end
						2'b10: begin
							res = fv + 8'h01;
							z_en = 1'b1;
						end
						default: begin
							res = fv - 8'h01;
							skip = (res == 8'h00);
						end
					endcase
				end
				12'b0011_????_????: begin
					byte_op = 1'b1;
					case (op[7:6])
						2'b00: begin
							res = {s_q.status[`ST_C], fv[7:1]};
							c_en = 1'b1;
							c_val = fv[0];
						end
						2'b01: begin
							res = {fv[6:0], s_q.status[`ST_C]};
							c_en = 1'b1;
							c_val = fv[7];
						end
						2'b10: res = {fv[3:0], fv[7:4]};
						default: begin
							res = fv + 8'h01;
							skip = (res == 8'h00);
						end
					endcase
				end
				12'b01??_????_????: begin
					case (op[9:8])
						2'b00: begin
							res = fv & ~mask;
							wr_en = 1'b1;
						end
						2'b01: begin
							res = fv | mask;
							wr_en = 1'b1;
						end
						2'b10: skip = ((fv & mask) == 8'h00);
						default: skip = ((fv & mask) != 8'h00);
					endcase
				end
				12'b1000_????_????: begin
					s_d.wreg = op[7:0];
					s_d.pc = s_q.stack0;
					s_d.stack0 = s_q.stack1;
					s_d.flush = 1'b1;
				end
				12'b1001_????_????: begin
					s_d.stack1 = s_q.stack0;
					s_d.stack0 = s_q.pc;
					s_d.pc = {s_q.status[`ST_PA_HI:`ST_PA_LO], 1'b0, op[7:0]};
					s_d.flush = 1'b1;
				end
				12'b101?_????_????: begin
					s_d.pc = {s_q.status[`ST_PA_HI:`ST_PA_LO], op[8:0]};
					s_d.flush = 1'b1;
				end
				12'b11??_????_????: begin
					w_en = 1'b1;
					z_en = (op[9:8] != 2'b00);
					case (op[9:8])
						2'b00: res = op[7:0];
						2'b01: res = s_q.wreg | op[7:0];
						2'b10: res = s_q.wreg & op[7:0];
						default: res = s_q.wreg ^ op[7:0];
					endcase
				end
				default: begin
				end
			endcase
			if (byte_op) begin
				wr_en = op[5];
				w_en = ~op[5];
			end
			if (w_en) begin
				s_d.wreg = res;
			end
			if (wr_en) begin
				case (fa)
					`FILE_STATUS: begin
						s_d.status = {res[7:5], s_q.status[`ST_TO:`ST_PD], res[2:0]};
					end
					`FILE_PORT: s_d.latch = res[`PIN_W-1:0];
					`FILE_PCL: begin
						s_d.pc = {s_q.status[`ST_PA_HI:`ST_PA_LO], 1'b0, res};
						s_d.flush = 1'b1;
					end
					`FILE_TIMER: begin
						s_d.files[fa] = res;
						s_d.psc_clr = ~s_q.option[`OPT_PSA];
					end
					default: s_d.files[fa] = res;
				endcase
			end
			if (byte_op || op[11:10] == 2'b01) begin
				if (fa == `FILE_PORT) begin
					s_d.last_pins = s_q.sync2;
				end
			end
			if (z_en) begin
				s_d.status[`ST_Z] = (res == 8'h00);
			end
			if (c_en) begin
				s_d.status[`ST_C] = c_val;
			end
			if (dc_en) begin
				s_d.status[`ST_DC] = dc_val;
			end
			if (skip) begin
				s_d.flush = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			s_q <= '0;
			s_q.flush <= 1'b1;
			s_q.status <= `STATUS_RST;
			s_q.option <= `OPTION_RST;
			s_q.dir <= `DIR_RST;
			s_q.av_wait <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign avs_rsp = '{waitrequest: s_q.av_wait, readdata: s_q.av_rdata};
	assign prog_addr = s_q.pc;
	assign pin_out = s_q.latch;
	assign pin_oe = s_q.dir;
	assign option_out = s_q.option;
	assign wdt_clear = s_q.wdt_clr;
	assign prescaler_clear = s_q.psc_clr;
	assign sleeping = s_q.sleeping;
endmodule : baseline_core
`default_nettype wire

// ---- hdl/core_params.svh ----
// constants for the baseline core: addresses, field positions, reset values
`ifndef CORE_PARAMS_SVH
`define CORE_PARAMS_SVH
`define PC_W 11
`define INSN_W 12
`define FILE_DEPTH 32
`define PIN_W 4
`define FILE_TIMER 5'h01
`define FILE_PCL 5'h02
`define FILE_STATUS 5'h03
`define FILE_PORT 5'h06
`define ST_C 0
`define ST_DC 1
`define ST_Z 2
`define ST_PD 3
`define ST_TO 4
`define ST_PA_LO 5
`define ST_PA_HI 6
`define ST_WAKE 7
`define OPT_PSA 3
`define OPT_WAKE_N 7
`define STATUS_RST 8'h18
`define OPTION_RST 8'hff
`define DIR_RST 4'hf
`define DIR_PORT_SEL 3'h6
`define AV_ADDR_W 4
`define AV_CTRL 2'h0
`define AV_CORE 2'h1
`define AV_PC 2'h2
`define AV_CONF 2'h3
`define CTRL_RUN 0
`define CORE_SLEEP 16
`endif

// ---- hdl/core_pkg.sv ----
// types shared by the baseline core
`default_nettype none
package core_pkg;
`include "core_params.svh"
	typedef struct packed {
		logic read;
		logic write;
		logic [`AV_ADDR_W-1:0] address;
		logic [31:0] writedata;
	} avs_req_t;
	typedef struct packed {
		logic waitrequest;
		logic [31:0] readdata;
	} avs_rsp_t;
	typedef struct packed {
		logic [`PC_W-1:0] pc;
		logic [`INSN_W-1:0] ir;
		logic flush;
		logic [7:0] wreg;
		logic [7:0] status;
		logic [`FILE_DEPTH-1:0][7:0] files;
		logic [`PC_W-1:0] stack0;
		logic [`PC_W-1:0] stack1;
		logic [7:0] option;
		logic [`PIN_W-1:0] dir;
		logic [`PIN_W-1:0] latch;
		logic [`PIN_W-1:0] sync1;
		logic [`PIN_W-1:0] sync2;
		logic [`PIN_W-1:0] last_pins;
		logic sleeping;
		logic run;
		logic wdt_clr;
		logic psc_clr;
		logic av_wait;
		logic [31:0] av_rdata;
	} core_st_t;
endpackage : core_pkg
`default_nettype wire

// ---- test/baseline_core_chk.sv ----
// port assertions for the core
`default_nettype none
`include "core_params.svh"
module core_chk
	import core_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire core_pkg::avs_req_t avs_req,
	input wire core_pkg::avs_rsp_t avs_rsp,
	input wire logic [`PC_W-1:0] prog_addr,
	input wire logic [`PIN_W-1:0] pin_oe,
	input wire logic [7:0] option_out,
	input wire logic wdt_clear,
	input wire logic prescaler_clear,
	input wire logic sleeping
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	a_wait_one: assert property ((avs_req.read || avs_req.write) && avs_rsp.waitrequest
		|=> !avs_rsp.waitrequest) else $error("request not answered");
	a_wait_idle: assert property (!(avs_req.read || avs_req.write) |=> avs_rsp.waitrequest)
		else $error("answer without request");
	a_wait_once: assert property (!avs_rsp.waitrequest |=> avs_rsp.waitrequest)
		else $error("answer held too long");
	a_sleep_pulse: assert property ($rose(sleeping) |-> wdt_clear && prescaler_clear)
		else $error("sleep without watchdog clear");
	a_sleep_halt: assert property (sleeping ##1 sleeping |-> $stable(prog_addr) && !wdt_clear)
		else $error("core runs while halted");
	a_wdt_psc: assert property (wdt_clear && option_out[`OPT_PSA] |-> prescaler_clear)
		else $error("prescaler kept on watchdog clear");
	a_timer_psc: assert property (prescaler_clear && !wdt_clear |-> !option_out[`OPT_PSA])
		else $error("timer clear with prescaler on watchdog");
	a_reset_vals: assert property ($fell(rst) |-> pin_oe == `DIR_RST && option_out == `OPTION_RST
		&& prog_addr == '0) else $error("bad values after reset");
	c_sleep: cover property ($rose(sleeping));
	c_timer: cover property (prescaler_clear && !wdt_clear);
	c_wdt: cover property (wdt_clear && !sleeping);
	c_wake: cover property ($fell(sleeping));
endmodule : core_chk
bind baseline_core core_chk u_chk (.clk_sys, .rst, .avs_req, .avs_rsp, .prog_addr, .pin_oe,
	.option_out, .wdt_clear, .prescaler_clear, .sleeping);
`default_nettype wire

// ---- test/baseline_core_instruction_execute_tb.sv ----
// self-checking bench for the core
`default_nettype none
`include "core_params.svh"
module baseline_core_instruction_execute_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import core_pkg::*;
	typedef struct packed {
		logic [11:0] op;
		logic [7:0] k1;
		logic [7:0] k2;
		logic [7:0] w;
		logic [2:0] f;
	} row_t;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	avs_req_t req = '0;
	avs_rsp_t rsp;
	logic [10:0] paddr;
	logic [11:0] pdata;
	logic [3:0] pin_in = 4'ha;
	logic [3:0] pin_out;
	logic [3:0] pin_oe;
	logic [7:0] opt;
	logic wdc;
	logic psc;
	logic slp;
	logic [31:0] q;
	int n_fail = 0;
	int n_compared = 0;
	int n_wdc = 0;
	int n_psc = 0;
	int wdc0 = 0;
	int psc0 = 0;
	logic [11:0] img [32] = '{12'hc01, 12'h030, 12'h5f0, 12'h6f0, 12'hc22, 12'h710, 12'hc33,
		12'h1d0, 12'ha18, 12'h92f, 12'hd80, 12'ha1b, 12'hcb7, 12'h002, 12'h006, 12'h004,
		12'h003, 12'ha21, 12'hc00, 12'h002, 12'hc05, 12'h026, 12'h021, 12'h206, 12'ha28,
		12'hc00, 12'h002, 12'h206, 12'h003, 12'ha2d, 12'h0, 12'h877};
	row_t rows [17] = '{
		'{12'h110, 8'h0f, 8'hf0, 8'hff, 3'h0},
		'{12'h150, 8'h0f, 8'hf0, 8'h00, 3'h4},
		'{12'h190, 8'h3c, 8'h3c, 8'h00, 3'h4},
		'{12'h350, 8'h81, 8'h00, 8'h02, 3'h1},
		'{12'h310, 8'h01, 8'h00, 8'h00, 3'h1},
		'{12'h3d0, 8'hff, 8'h11, 8'h00, 3'h0},
		'{12'h2d0, 8'h02, 8'h11, 8'h01, 3'h0},
		'{12'h1d0, 8'h0f, 8'h01, 8'h10, 3'h2},
		'{12'h090, 8'h05, 8'h05, 8'h00, 3'h7},
		'{12'h210, 8'h00, 8'h55, 8'h00, 3'h4},
		'{12'h130, 8'h0f, 8'hf0, 8'hf0, 3'h0},
		'{12'h070, 8'h0f, 8'h21, 8'h21, 3'h4},
		'{12'hd0f, 8'h00, 8'hf0, 8'hff, 3'h0},
		'{12'he00, 8'h00, 8'hf0, 8'h00, 3'h4},
		'{12'hfff, 8'h00, 8'hff, 8'h00, 3'h4},
		'{12'hc00, 8'h00, 8'hf0, 8'h00, 3'h0},
		'{12'h040, 8'h00, 8'h55, 8'h00, 3'h4}
	};
	always #2.5 clk_sys = ~clk_sys;
	baseline_core dut (.clk_sys(clk_sys), .rst(rst), .avs_req(req), .avs_rsp(rsp),
		.prog_addr(paddr), .prog_data(pdata), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe(pin_oe), .option_out(opt), .wdt_clear(wdc), .prescaler_clear(psc),
		.sleeping(slp));
	prog_mem u_mem (.prog_addr(paddr), .prog_data(pdata));
	// count clear pulses seen at each rising edge
	always @(posedge clk_sys) begin
		if (wdc === 1'b1)
			n_wdc <= n_wdc + 1;
		if (psc === 1'b1)
			n_psc <= n_psc + 1;
	end
	task report_and_stop;
		$display("compared %0d, failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : report_and_stop
	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic av(logic wr, logic [3:0] a, logic [31:0] d);
		int i;
		@(posedge clk_sys);
		req.read <= !wr;
		req.write <= wr;
		req.address <= a;
		req.writedata <= d;
		for (i = 0; i < 20; i++) begin
			@(posedge clk_sys);
			if (rsp.waitrequest === 1'b0)
				break;
		end
		if (i == 20) begin
			n_fail++;
			report_and_stop;
		end
		q = rsp.readdata;
		req.read <= 1'b0;
		req.write <= 1'b0;
	endtask : av
	task rst_core;
		rst <= 1'b1;
		repeat (6) @(posedge clk_sys);
		rst <= 1'b0;
	endtask : rst_core
	// start the core and let the program settle in its loop
	task go(logic [11:0] w0);
		wdc0 = n_wdc;
		psc0 = n_psc;
		u_mem.mem[0] = w0;
		av(1'b1, 4'h0, 32'h1);
		repeat (40) @(posedge clk_sys);
		av(1'b0, 4'h4, 32'h0);
	endtask : go
	initial begin
		rst_core;
		foreach (img[i])
			u_mem.mem[16 + i] = img[i];
		foreach (rows[r]) begin
			rst_core;
			u_mem.mem[1] = 12'h030;
			u_mem.mem[2] = {4'hc, rows[r].k2};
			u_mem.mem[3] = rows[r].op;
			u_mem.mem[4] = 12'ha04;
			u_mem.mem[5] = 12'ha05;
			go({4'hc, rows[r].k1});
			chk("row result", {rows[r].w, rows[r].f}, {q[7:0], q[10:8]});
		end
		rst_core;
		av(1'b1, 4'h4, 32'hffff);
		av(1'b0, 4'h4, 32'h0);
		chk("core after reset", 32'h1800, q);
		av(1'b0, 4'hc, 32'h0);
		chk("conf after reset", 32'hfff, q);
		rst_core;
		go(12'ha10);
		chk("skip result", 32'ha3, q[7:0]);
		rst_core;
		go(12'ha19);
		chk("call result", 32'hf7, q[7:0]);
		rst_core;
		go(12'ha1c);
		chk("sleep core", 32'h110b7, q);
		chk("sleep pin", 32'h1, slp);
		chk("option", 32'hb7, opt);
		chk("direction", 32'h7, pin_oe);
		chk("wdt pulses", 32'h2, n_wdc - wdc0);
		chk("psc pulses", 32'h1, n_psc - psc0);
		rst_core;
		go(12'ha22);
		chk("pin read", 32'ha, q[7:0]);
		chk("pin latch", 32'h5, pin_out);
		chk("timer psc pulses", 32'h1, n_psc - psc0);
		chk("timer wdt pulses", 32'h0, n_wdc - wdc0);
		rst_core;
		go(12'ha29);
		chk("asleep core", 32'h1100a, q);
		pin_in <= 4'h5;
		repeat (10) @(posedge clk_sys);
		av(1'b0, 4'h4, 32'h0);
		chk("woken core", 32'h900a, q);
		report_and_stop;
	end
endmodule : baseline_core_instruction_execute_tb
`default_nettype wire

// ---- test/prog_mem.sv ----
// program memory model answering fetches at once
`default_nettype none
`include "core_params.svh"
module prog_mem
	import core_pkg::*;
(
	input wire logic [`PC_W-1:0] prog_addr,
	output logic [`INSN_W-1:0] prog_data
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [`INSN_W-1:0] mem [0:(1<<`PC_W)-1];
	initial begin
		foreach (mem[i])
			mem[i] = '0;
	end
	assign prog_data = mem[prog_addr];
endmodule : prog_mem
`default_nettype wire
